// ### inc/ctbx_pkg.sv
// shared constants and types for the branch/test/unpack/xor execution block
`default_nettype none
package ctbx_pkg;
  // opcodes
  localparam logic [7:0] OP_GE_LOOP_BYTE = 8'h5d;
  localparam logic [7:0] OP_GE_LOOP_HALF = 8'h1d;
  localparam logic [7:0] OP_NE_LOOP_BYTE = 8'h7d;
  localparam logic [7:0] OP_NE_LOOP_HALF = 8'h3d;
  localparam logic [7:0] OP_PROBE_BYTE = 8'h2b;
  localparam logic [7:0] OP_PROBE_HALF = 8'h2a;
  localparam logic [7:0] OP_PROBE_WORD = 8'h28;
  localparam logic [7:0] OP_BCD_SPREAD = 8'h0f;
  localparam logic [7:0] OP_EXOR_B2 = 8'hb7;
  localparam logic [7:0] OP_EXOR_H2 = 8'hb6;
  localparam logic [7:0] OP_EXOR_W2 = 8'hb4;
  localparam logic [7:0] OP_EXOR_B3 = 8'hf7;
  localparam logic [7:0] OP_EXOR_H3 = 8'hf6;
  localparam logic [7:0] OP_EXOR_W3 = 8'hf4;
  // operating-system opcodes (16 bit)
  localparam logic [15:0] OP_INVOKE_PS = 16'h30ac;
  localparam logic [15:0] OP_USER_INVOKE_PS = 16'h30c0;
  localparam logic [15:0] OP_RESUME_PRIOR = 16'h30c8;
  // nibble field positions of the spread result
  localparam int BCD_LO1_POS = 0;
  localparam int BCD_LO2_POS = 4;
  localparam int BCD_HI1_POS = 8;
  localparam int BCD_HI2_POS = 12;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    CTBX_SZ_BYTE = 2'b00,
    CTBX_SZ_HALF = 2'b01,
    CTBX_SZ_WORD = 2'b10
  } ctbx_size_t;

  typedef enum logic [2:0] {
    CTBX_MODE_PLAIN = 3'b000,
    CTBX_MODE_REG = 3'b001,
    CTBX_MODE_LITERAL = 3'b010,
    CTBX_MODE_IMMED = 3'b011,
    CTBX_MODE_EXPAND = 3'b100
  } ctbx_mode_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } ctbx_flags_t;

  typedef struct packed {
    logic valid;
    logic [15:0] opcode;
    logic [31:0] src1;
    logic [31:0] src2;
    logic [31:0] dst_in;
    logic [15:0] disp;
    logic [31:0] pc;
    logic lt;
    logic eq;
    ctbx_mode_t src1_mode;
    ctbx_mode_t src2_mode;
    ctbx_mode_t dst_mode;
    ctbx_size_t dst_size;
  } ctbx_req_t;

  typedef struct packed {
    logic done;
    logic dst_we;
    logic [31:0] dst_out;
    logic pc_we;
    logic [31:0] pc_out;
    logic flags_we;
    ctbx_flags_t flags;
    logic exc_invalid_desc;
    logic exc_illegal_op;
    logic ps_explicit;
    logic ps_implicit;
  } ctbx_resp_t;
endpackage
`default_nettype wire

// ### rtl/ctbx_loop_unit.sv
// decrement-and-test loop arithmetic for byte and halfword forms
`default_nettype none
module ctbx_loop_unit
  import ctbx_pkg::*;
(
  input wire logic half,
  input wire logic [31:0] dst_in,
  input wire logic [15:0] disp,
  input wire logic [31:0] pc,
  output logic [31:0] dec_val,
  output logic go_branch,
  output logic [31:0] target
);
  logic [15:0] dec16;
  logic [7:0] dec8;
  logic [31:0] sign_extend_disp;

  always_comb begin
    dec8 = dst_in[7:0] - 8'h01;
    dec16 = dst_in[15:0] - 16'h0001;
    sign_extend_disp = half ? {{16{disp[15]}}, disp} : {{24{disp[7]}}, disp[7:0]};
    go_branch = half ? ($signed(dec16) > $signed(16'hffff)) : ($signed(dec8) > $signed(8'hff));
    dec_val = half ? {dst_in[31:16], dec16} : {dst_in[31:8], dec8};
    target = pc + sign_extend_disp;
  end
endmodule
`default_nettype wire

// ### rtl/ctbx_logic_unit.sv
// exclusive-or, nibble spread and probe flag arithmetic
`default_nettype none
module ctbx_logic_unit
  import ctbx_pkg::*;
(
  input wire ctbx_size_t size,
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  output logic [31:0] exor_val,
  output logic [15:0] spread_val,
  output ctbx_flags_t exor_flags,
  output ctbx_flags_t probe_flags
);
  function automatic logic msb_of(input ctbx_size_t s, input logic [31:0] x);
    case (s)
      CTBX_SZ_BYTE: msb_of = x[7];
      CTBX_SZ_HALF: msb_of = x[15];
      default: msb_of = x[31];
    endcase
  endfunction

  function automatic logic [31:0] fit(input ctbx_size_t s, input logic [31:0] x);
    case (s)
      CTBX_SZ_BYTE: fit = {24'h000000, x[7:0]};
      CTBX_SZ_HALF: fit = {16'h0000, x[15:0]};
      default: fit = x;
    endcase
  endfunction

  logic [31:0] raw;

  always_comb begin
    raw = a ^ b;
    exor_val = fit(size, raw);
    exor_flags.n = msb_of(size, exor_val);
    exor_flags.z = (exor_val == RST_WORD);
    exor_flags.c = 1'b0;
    exor_flags.v = (raw != exor_val);
    probe_flags.n = msb_of(size, a);
    probe_flags.z = (fit(size, a) == RST_WORD);
    probe_flags.c = 1'b0;
    probe_flags.v = 1'b0;
    spread_val = 16'h0000;
    spread_val[BCD_HI1_POS +: 4] = a[7:4];
    spread_val[BCD_HI2_POS +: 4] = b[7:4];
    spread_val[BCD_LO1_POS +: 4] = a[3:0];
    spread_val[BCD_LO2_POS +: 4] = b[3:0];
  end
endmodule
`default_nettype wire

// ### rtl/ctbx_exec.sv
// execution stage for loop branches, probes, nibble spread, exclusive-or and process switch events
// Behaviour
// - opcodes 0x5d and 0x1d are the byte and halfword greater-or-equal loop branch.
// - on less-than the loop decrements the destination and branches if the result exceeds -1.
// - the displacement is signed 8 bit for byte and signed 16 bit for halfword, sign extended.
// - loops fault invalid-descriptor on literal, immediate or expanded destination, flags untouched.
// - opcodes 0x7d and 0x3d are the not-equal loop, acting when equal holds.
// - opcodes 0x2b, 0x2a, 0x28 are probes writing only the flags.
// - probes set n from sign and z on zero, clear c and v, never fault.
// - spread puts the first source high nibble at 8-11 and the second at 12-15.
// - spread puts the first source low nibble at 0-3 and the second at 4-7.
// - spread keeps flags and faults on expanded operands or a literal or immediate destination.
// - opcodes 0xb7, 0xb6, 0xb4 replace the destination with destination xor source.
// - opcodes 0xf7, 0xf6, 0xf4 write second source xor first source.
// - exclusive-or sets n from msb, z on zero, clears c, sets v on truncation.
// - exclusive-or faults illegal-operand on a literal or immediate destination.
// - invoke, user invoke and resume opcodes raise an explicit process switch.
// - reset request, full interrupt or a switching exception raise an implicit process switch.
`default_nettype none
module ctbx_exec
  import ctbx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire ctbx_req_t req,
  input wire logic reset_request,
  input wire logic full_irq_request,
  input wire logic switch_exception,
  output ctbx_resp_t resp
);
  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic [7:0] op8;
  logic is_ge, is_ne, is_loop, loop_half, is_probe, is_spread, is_exor2, is_exor3, is_exor, is_os;
  ctbx_size_t op_size;

  assign op8 = req.opcode[7:0];

  always_comb begin
    is_ge = 1'b0;
    is_ne = 1'b0;
    loop_half = 1'b0;
    is_probe = 1'b0;
    is_spread = 1'b0;
    is_exor2 = 1'b0;
    is_exor3 = 1'b0;
    op_size = CTBX_SZ_WORD;
    is_os = 1'b0;
    if (req.opcode[15:8] != 8'h00) begin
      is_os = (req.opcode == OP_INVOKE_PS) || (req.opcode == OP_USER_INVOKE_PS) ||
              (req.opcode == OP_RESUME_PRIOR);
    end else begin
      case (op8)
        OP_GE_LOOP_BYTE: begin
          is_ge = 1'b1;
          op_size = CTBX_SZ_BYTE;
        end
        OP_GE_LOOP_HALF: begin
          is_ge = 1'b1;
          loop_half = 1'b1;
          op_size = CTBX_SZ_HALF;
        end
        OP_NE_LOOP_BYTE: begin
          is_ne = 1'b1;
          op_size = CTBX_SZ_BYTE;
        end
        OP_NE_LOOP_HALF: begin
          is_ne = 1'b1;
          loop_half = 1'b1;
          op_size = CTBX_SZ_HALF;
        end
        OP_PROBE_BYTE: begin
          is_probe = 1'b1;
          op_size = CTBX_SZ_BYTE;
        end
        OP_PROBE_HALF: begin
          is_probe = 1'b1;
          op_size = CTBX_SZ_HALF;
        end
        OP_PROBE_WORD: begin
          is_probe = 1'b1;
        end
        OP_BCD_SPREAD: begin
          is_spread = 1'b1;
          op_size = CTBX_SZ_HALF;
        end
        OP_EXOR_B2: begin
          is_exor2 = 1'b1;
          op_size = CTBX_SZ_BYTE;
        end
        OP_EXOR_H2: begin
          is_exor2 = 1'b1;
          op_size = CTBX_SZ_HALF;
        end
        OP_EXOR_W2: begin
          is_exor2 = 1'b1;
        end
        OP_EXOR_B3: begin
          is_exor3 = 1'b1;
          op_size = CTBX_SZ_BYTE;
        end
        OP_EXOR_H3: begin
          is_exor3 = 1'b1;
          op_size = CTBX_SZ_HALF;
        end
        OP_EXOR_W3: begin
          is_exor3 = 1'b1;
        end
        default: begin
          op_size = CTBX_SZ_WORD;
        end
      endcase
    end
  end

  assign is_loop = is_ge | is_ne;
  assign is_exor = is_exor2 | is_exor3;

  ////////////////////////////////////////////////////////////////////////////
  // datapath units
  logic [31:0] dec_val, target, exor_val, lu_a, lu_b;
  logic [15:0] spread_val;
  logic go_branch;
  ctbx_flags_t exor_flags, probe_flags;

  // two-operand xor uses destination as second source
  assign lu_a = req.src1;
  assign lu_b = is_exor2 ? req.dst_in : req.src2;

  ctbx_loop_unit u_loop (
    .half(loop_half),
    .dst_in(req.dst_in),
    .disp(req.disp),
    .pc(req.pc),
    .dec_val(dec_val),
    .go_branch(go_branch),
    .target(target)
  );

  ctbx_logic_unit u_logic (
    .size(op_size),
    .a(lu_a),
    .b(lu_b),
    .exor_val(exor_val),
    .spread_val(spread_val),
    .exor_flags(exor_flags),
    .probe_flags(probe_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // operand mode checks
  function automatic logic lit_or_imm(input ctbx_mode_t m);
    lit_or_imm = (m == CTBX_MODE_LITERAL) || (m == CTBX_MODE_IMMED);
  endfunction

  logic loop_bad, spread_bad, exor_bad, loop_cond;

  always_comb begin
    loop_bad = lit_or_imm(req.dst_mode) || (req.dst_mode == CTBX_MODE_EXPAND);
    spread_bad = lit_or_imm(req.dst_mode) || (req.dst_mode == CTBX_MODE_EXPAND) ||
                 (req.src1_mode == CTBX_MODE_EXPAND) || (req.src2_mode == CTBX_MODE_EXPAND);
    exor_bad = lit_or_imm(req.dst_mode);
    loop_cond = is_ge ? req.lt : req.eq;
  end

  ////////////////////////////////////////////////////////////////////////////
  // result register
  ctbx_resp_t next_resp;

  always_comb begin
    next_resp = '0;
    next_resp.pc_out = req.pc;
    next_resp.dst_out = req.dst_in;
    if (req.valid) begin
      next_resp.done = 1'b1;
      next_resp.ps_explicit = is_os;
      if (is_loop) begin
        if (loop_bad) begin
          next_resp.exc_invalid_desc = 1'b1;
        end else if (loop_cond) begin
          next_resp.dst_we = 1'b1;
          next_resp.dst_out = dec_val;
          next_resp.pc_we = go_branch;
          next_resp.pc_out = go_branch ? target : req.pc;
        end
      end else if (is_probe) begin
        next_resp.flags_we = 1'b1;
        next_resp.flags = probe_flags;
      end else if (is_spread) begin
        if (spread_bad) begin
          next_resp.exc_invalid_desc = 1'b1;
        end else begin
          next_resp.dst_we = 1'b1;
          next_resp.dst_out = {16'h0000, spread_val};
        end
      end else if (is_exor) begin
        if (exor_bad) begin
          next_resp.exc_illegal_op = 1'b1;
        end else begin
          next_resp.dst_we = 1'b1;
          next_resp.dst_out = exor_val;
          next_resp.flags_we = 1'b1;
          next_resp.flags = exor_flags;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      resp <= '0;
    end else begin
      resp <= next_resp;
      resp.ps_implicit <= reset_request | full_irq_request | switch_exception;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  loop_exc_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_loop && loop_bad |=> resp.exc_invalid_desc && !resp.flags_we && !resp.dst_we)
    else $error("loop bad mode not faulted");
  loop_branch_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_ge && !loop_bad && req.lt && !loop_half && req.dst_in[7:0] == 8'h05
    |=> resp.dst_we && resp.pc_we && resp.dst_out[7:0] == 8'h04)
    else $error("ge loop did not branch");
  loop_stop_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_loop && !loop_bad && loop_cond && !loop_half && req.dst_in[7:0] == 8'h00
    |=> resp.dst_we && !resp.pc_we)
    else $error("loop branched at minus one");
  ne_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_ne && !req.eq |=> !resp.dst_we && !resp.pc_we)
    else $error("ne loop acted without equal");
  probe_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_probe |=> resp.flags_we && !resp.dst_we && !resp.flags.c && !resp.flags.v &&
    !resp.exc_illegal_op && !resp.exc_invalid_desc)
    else $error("probe flags wrong");
  spread_val_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_spread && !spread_bad |=> resp.dst_out[15:0] ==
    {$past(req.src2[7:4]), $past(req.src1[7:4]), $past(req.src2[3:0]), $past(req.src1[3:0])})
    else $error("spread layout wrong");
  spread_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_spread |=> !resp.flags_we)
    else $error("spread touched flags");
  exor_dst_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_exor && lit_or_imm(req.dst_mode) |=> resp.exc_illegal_op && !resp.dst_we)
    else $error("xor bad destination accepted");
  exor_word_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_exor2 && op8 == OP_EXOR_W2 && !exor_bad
    |=> resp.dst_out == ($past(req.src1) ^ $past(req.dst_in)) && !resp.flags.c)
    else $error("xor word result wrong");
  os_switch_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && req.opcode == OP_RESUME_PRIOR |=> resp.ps_explicit)
    else $error("explicit switch missed");
  implicit_a: assert property (@(posedge ref_clk) disable iff (reset)
    full_irq_request |=> resp.ps_implicit)
    else $error("implicit switch missed");
  ge_decode_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && req.opcode == {8'h00, OP_GE_LOOP_HALF} |-> is_ge && loop_half && !is_ne)
    else $error("ge loop opcode not decoded");
  ne_decode_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && req.opcode == {8'h00, OP_NE_LOOP_BYTE} |-> is_ne && !loop_half && !is_ge)
    else $error("ne loop opcode not decoded");
  half_branch_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_ge && loop_half && !loop_bad && req.lt && req.dst_in[15:0] == 16'h0001 &&
    req.disp == 16'h8000 |=> resp.pc_we && resp.pc_out == $past(req.pc) + 32'hffff_8000)
    else $error("halfword displacement not sign extended");
  half_stop_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_loop && loop_half && !loop_bad && loop_cond && req.dst_in[15:0] == 16'h0000
    |=> resp.dst_we && !resp.pc_we && resp.dst_out[15:0] == 16'hffff)
    else $error("halfword loop branched at minus one");
  probe_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_probe && op_size == CTBX_SZ_WORD && req.src1 == 32'h0000_0000
    |=> resp.flags.z && !resp.flags.n)
    else $error("probe zero flag wrong");
  spread_low_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_spread && !spread_bad |=> resp.dst_out[31:16] == 16'h0000 &&
    resp.dst_out[7:0] == {$past(req.src2[3:0]), $past(req.src1[3:0])})
    else $error("spread low nibbles wrong");
  spread_fault_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_spread && spread_bad |=> resp.exc_invalid_desc && !resp.dst_we)
    else $error("spread bad descriptor accepted");
  exor_three_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_exor3 && op8 == OP_EXOR_W3 && !exor_bad
    |=> resp.dst_we && resp.dst_out == ($past(req.src2) ^ $past(req.src1)))
    else $error("three operand xor result wrong");
  exor_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_exor && !exor_bad
    |=> resp.flags_we && !resp.flags.c && resp.flags.z == (resp.dst_out == 32'h0000_0000))
    else $error("xor flags wrong");
  exor_trunc_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.valid && is_exor2 && op8 == OP_EXOR_B2 && !exor_bad &&
    (req.src1[31:8] ^ req.dst_in[31:8]) != 24'h000000 |=> resp.flags.v)
    else $error("xor truncation not flagged");
  ps_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    !reset_request && !full_irq_request && !switch_exception |=> !resp.ps_implicit)
    else $error("implicit switch without event");
endmodule
`default_nettype wire

// ### verification/ctbx_exec_tb.sv
// self-checking bench for the ctbx execution stage
`default_nettype none
module ctbx_exec_tb
  import ctbx_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] pc0 = 32'h0000_1000;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic reset_request = 1'b0;
  logic full_irq_request = 1'b0;
  logic switch_exception = 1'b0;
  ctbx_req_t req = '0;
  ctbx_resp_t resp;
  int n_mismatch = 0;
  int tests_run = 0;

  always #2 ref_clk = ~ref_clk;

  ctbx_exec uut (
    .ref_clk(ref_clk),
    .reset(reset),
    .req(req),
    .reset_request(reset_request),
    .full_irq_request(full_irq_request),
    .switch_exception(switch_exception),
    .resp(resp)
  );

////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk1(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk32(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_flags(input ctbx_flags_t e, input ctbx_flags_t g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value flags expected %b seen %b", e, g);
    end
  endtask

  // called at a falling edge; result is read at the next one
  task automatic issue(input logic [15:0] op, input logic [31:0] s1, s2, d, input logic [15:0] dsp = '0,
      input logic lt = 1'b0, eq = 1'b0, input ctbx_mode_t md = CTBX_MODE_REG, m1 = CTBX_MODE_REG,
      m2 = CTBX_MODE_REG);
    req.valid = 1'b1;
    req.opcode = op;
    req.src1 = s1;
    req.src2 = s2;
    req.dst_in = d;
    req.disp = dsp;
    req.pc = pc0;
    req.lt = lt;
    req.eq = eq;
    req.dst_mode = md;
    req.src1_mode = m1;
    req.src2_mode = m2;
    @(negedge ref_clk);
    chk1("done", 1'b1, resp.done);
  endtask

  task automatic quiet();
    req.valid = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic chk_out(input logic dwe, input logic [31:0] dv, input logic fwe, input logic ei, input logic eo);
    chk1("dst_we", dwe, resp.dst_we);
    if (dwe) begin
      chk32("dst_out", dv, resp.dst_out);
    end
    chk1("flags_we", fwe, resp.flags_we);
    chk1("exc_invalid_desc", ei, resp.exc_invalid_desc);
    chk1("exc_illegal_op", eo, resp.exc_illegal_op);
  endtask

  task automatic chk_loop(input logic [31:0] dv, input logic [31:0] pv);
    chk_out(1'b1, dv, 1'b0, 1'b0, 1'b0);
    chk32("pc_out", pv, resp.pc_out);
  endtask

////////////////////////////////////////
  task automatic t_loops();
    issue(OP_GE_LOOP_BYTE, '0, '0, 32'h1234_5605, 16'h00fe, 1'b1);
    chk_loop(32'h1234_5604, 32'h0000_0ffe);
    chk1("pc_we", 1'b1, resp.pc_we);
    issue(OP_GE_LOOP_BYTE, '0, '0, 32'h1234_5605, 16'h00fe, 1'b0);
    chk1("dst_we", 1'b0, resp.dst_we);
    chk1("pc_we", 1'b0, resp.pc_we);
    issue(OP_GE_LOOP_BYTE, '0, '0, 32'h1234_5600, 16'h00fe, 1'b1);
    chk_loop(32'h1234_56ff, pc0);
    issue(OP_GE_LOOP_BYTE, '0, '0, 32'h0000_0080, 16'h1210, 1'b1);
    chk_loop(32'h0000_007f, 32'h0000_1010);
    issue(OP_GE_LOOP_HALF, '0, '0, 32'haaaa_0001, 16'h8000, 1'b1);
    chk_loop(32'haaaa_0000, 32'hffff_9000);
    issue(OP_NE_LOOP_BYTE, '0, '0, 32'h0000_0003, 16'h0005, 1'b0, 1'b1);
    chk_loop(32'h0000_0002, 32'h0000_1005);
    chk1("pc_we", 1'b1, resp.pc_we);
    issue(OP_NE_LOOP_HALF, '0, '0, 32'h0000_8000, 16'hfff0, 1'b0, 1'b1);
    chk_loop(32'h0000_7fff, 32'h0000_0ff0);
    issue(OP_NE_LOOP_BYTE, '0, '0, 32'h0000_0003, 16'h0005, 1'b1, 1'b0);
    chk1("dst_we", 1'b0, resp.dst_we);
    chk1("pc_we", 1'b0, resp.pc_we);
    issue(OP_GE_LOOP_HALF, '0, '0, 32'h0000_0000, 16'h0010, 1'b1);
    chk_loop(32'h0000_ffff, pc0);
    chk1("pc_we", 1'b0, resp.pc_we);
    quiet();
    $display("test loops done");
  endtask

  task automatic t_loop_fault();
    ctbx_mode_t bad[3] = '{CTBX_MODE_LITERAL, CTBX_MODE_IMMED, CTBX_MODE_EXPAND};
    logic [7:0] ops[4] = '{OP_GE_LOOP_BYTE, OP_GE_LOOP_HALF, OP_NE_LOOP_BYTE, OP_NE_LOOP_HALF};
    foreach (ops[i]) begin
      foreach (bad[j]) begin
        issue({8'h00, ops[i]}, '0, '0, 32'h0000_0005, 16'h0002, 1'b1, 1'b1, bad[j]);
        chk_out(1'b0, '0, 1'b0, 1'b1, 1'b0);
        chk1("pc_we", 1'b0, resp.pc_we);
      end
    end
    quiet();
    $display("test loop faults done");
  endtask

  task automatic t_probe();
    logic [7:0] op[7] = '{OP_PROBE_BYTE, OP_PROBE_BYTE, OP_PROBE_HALF, OP_PROBE_HALF, OP_PROBE_WORD,
        OP_PROBE_WORD, OP_PROBE_WORD};
    logic [31:0] src[7] = '{32'h0000_0080, 32'h0000_0100, 32'h0001_8000, 32'hffff_0000, 32'h8000_0000,
        32'h0000_0000, 32'h7fff_ffff};
    ctbx_flags_t f[7] = '{4'h8, 4'h4, 4'h8, 4'h4, 4'h8, 4'h4, 4'h0};
    foreach (op[i]) begin
      issue({8'h00, op[i]}, src[i], '0, 32'hffff_ffff, '0, 1'b1, 1'b1, CTBX_MODE_REG, CTBX_MODE_LITERAL);
      chk_out(1'b0, '0, 1'b1, 1'b0, 1'b0);
      chk1("pc_we", 1'b0, resp.pc_we);
      chk_flags(f[i], resp.flags);
    end
    quiet();
    $display("test probes done");
  endtask

  task automatic t_spread();
    ctbx_mode_t bd[5] = '{CTBX_MODE_REG, CTBX_MODE_REG, CTBX_MODE_LITERAL, CTBX_MODE_IMMED, CTBX_MODE_EXPAND};
    ctbx_mode_t b1[5] = '{CTBX_MODE_EXPAND, CTBX_MODE_REG, CTBX_MODE_REG, CTBX_MODE_REG, CTBX_MODE_REG};
    ctbx_mode_t b2[5] = '{CTBX_MODE_REG, CTBX_MODE_EXPAND, CTBX_MODE_REG, CTBX_MODE_REG, CTBX_MODE_REG};
    issue(OP_BCD_SPREAD, 32'h0000_0087, 32'h0000_00c5, 32'hffff_ffff, '0, 1'b0, 1'b0, CTBX_MODE_REG,
        CTBX_MODE_LITERAL);
    chk_out(1'b1, 32'h0000_c857, 1'b0, 1'b0, 1'b0);
    foreach (bd[i]) begin
      issue(OP_BCD_SPREAD, 32'h0000_0087, 32'h0000_00c5, '0, '0, 1'b0, 1'b0, bd[i], b1[i], b2[i]);
      chk_out(1'b0, '0, 1'b0, 1'b1, 1'b0);
    end
    quiet();
    $display("test spread done");
  endtask

  task automatic t_exor();
    logic [7:0] op[6] = '{OP_EXOR_B2, OP_EXOR_H2, OP_EXOR_W2, OP_EXOR_B3, OP_EXOR_H3, OP_EXOR_W3};
    logic [31:0] s1[6] = '{32'h0000_010f, 32'h0000_1234, 32'hf000_0000, 32'h0000_0001, 32'h0003_0001,
        32'h0000_0005};
    logic [31:0] s2[6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0081, 32'h0001_0001,
        32'h0000_0005};
    logic [31:0] d[6] = '{32'h0000_00f0, 32'h0000_1234, 32'h0000_000f, 32'h5a5a_5a5a, 32'h5a5a_5a5a,
        32'h5a5a_5a5a};
    logic [31:0] v[6] = '{32'h0000_00ff, 32'h0000_0000, 32'hf000_000f, 32'h0000_0080, 32'h0000_0000,
        32'h0000_0000};
    ctbx_flags_t f[6] = '{4'h9, 4'h4, 4'h8, 4'h8, 4'h5, 4'h4};
    foreach (op[i]) begin
      issue({8'h00, op[i]}, s1[i], s2[i], d[i], '0, 1'b1, 1'b1, CTBX_MODE_REG, CTBX_MODE_EXPAND,
          CTBX_MODE_IMMED);
      chk_out(1'b1, v[i], 1'b1, 1'b0, 1'b0);
      chk_flags(f[i], resp.flags);
    end
    foreach (op[i]) begin
      issue({8'h00, op[i]}, s1[i], s2[i], d[i], '0, 1'b0, 1'b0, CTBX_MODE_LITERAL);
      chk_out(1'b0, '0, 1'b0, 1'b0, 1'b1);
      issue({8'h00, op[i]}, s1[i], s2[i], d[i], '0, 1'b0, 1'b0, CTBX_MODE_IMMED);
      chk_out(1'b0, '0, 1'b0, 1'b0, 1'b1);
    end
    quiet();
    $display("test exor done");
  endtask

  task automatic t_switch();
    logic [15:0] os[3] = '{OP_INVOKE_PS, OP_USER_INVOKE_PS, OP_RESUME_PRIOR};
    foreach (os[i]) begin
      issue(os[i], '0, '0, '0);
      chk1("ps_explicit", 1'b1, resp.ps_explicit);
    end
    // unknown opcode only completes
    issue(16'h0001, '0, '0, '0);
    chk_out(1'b0, '0, 1'b0, 1'b0, 1'b0);
    chk1("ps_explicit", 1'b0, resp.ps_explicit);
    quiet();
    for (int i = 0; i < 4; i++) begin
      reset_request = (i == 0);
      full_irq_request = (i == 1);
      switch_exception = (i == 2);
      @(negedge ref_clk);
      chk1("ps_implicit", (i < 3), resp.ps_implicit);
    end
    $display("test switch done");
  endtask

  // mid-run reset clears every result, then the next cycle is served
  task automatic t_reset();
    issue(OP_GE_LOOP_BYTE, '0, '0, 32'h0000_0005, 16'h00fe, 1'b1);
    chk_loop(32'h0000_0004, 32'h0000_0ffe);
    reset = 1'b1;
    full_irq_request = 1'b1;
    @(negedge ref_clk);
    chk1("done", 1'b0, resp.done);
    chk1("dst_we", 1'b0, resp.dst_we);
    chk1("ps_implicit", 1'b0, resp.ps_implicit);
    reset = 1'b0;
    full_irq_request = 1'b0;
    issue(OP_EXOR_W3, 32'h0000_00ff, 32'h0000_0f0f, '0);
    chk_out(1'b1, 32'h0000_0ff0, 1'b1, 1'b0, 1'b0);
    chk_flags(4'h0, resp.flags);
    quiet();
    $display("test reset done");
  endtask

////////////////////////////////////////
  initial begin
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    t_loops();
    t_loop_fault();
    t_probe();
    t_spread();
    t_exor();
    t_switch();
    t_reset();
    end_sim();
  end

  initial begin
    #40000;
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
